// ### include/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define ADDR_FIXED 3'h3
`define BIT_LAST 3'h7
`define REF_SETTLE_MS 12
`endif

// ### include/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef struct packed {
        logic scl_oe_n;
        logic sda_oe_n;
    } bus_drive_t;

    typedef struct packed {
        logic [13:0] data;
        logic trailing_sub_bit_high;
        logic trailing_sub_bit_low;
    } conv_result_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_AACK = 6'h04,
        ST_CONV = 6'h08,
        ST_TX   = 6'h10,
        ST_MACK = 6'h20
    } seq_state_t;
endpackage
`default_nettype wire

// ### tb/adc_power_reference_sequencer_test.sv
`default_nettype none
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module adc_power_reference_sequencer_test import adc_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic m_scl, m_sda, hung, scl_out, sda_out;
    bus_pins_t bus_in;
    bus_drive_t bus_drive;
    logic [3:0] address_select_pins = 4'hA;
    logic reference_adjust_pin = 1'b0;
    logic conv_done = 1'b0;
    conv_result_t conv_result = '0;
    logic conv_start, converter_powered, reference_enabled, reference_buffer_enabled;
    int err_total = 0;
    int checks = 0;
    int conv_count = 0;
    always #10 mclk = ~mclk;
    // Pull-ups: a wire is low while anyone pulls it
    assign bus_in.scl = m_scl & (bus_drive.scl_oe_n | scl_out);
    assign bus_in.sda = m_sda & (bus_drive.sda_oe_n | sda_out);
    adc_power_reference_sequencer u_adc_power_reference_sequencer (
        .mclk(mclk), .reset_n(reset_n), .bus_in(bus_in), .bus_drive(bus_drive),
        .scl_out(scl_out), .sda_out(sda_out), .address_select_pins(address_select_pins),
        .reference_adjust_pin(reference_adjust_pin), .conv_done(conv_done),
        .conv_result(conv_result), .conv_start(conv_start),
        .converter_powered(converter_powered), .reference_enabled(reference_enabled),
        .reference_buffer_enabled(reference_buffer_enabled));
    bus_master_model u_bus_master_model (
        .mclk(mclk), .scl(bus_in.scl), .sda(bus_in.sda), .scl_drv(m_scl), .sda_drv(m_sda),
        .hung(hung));
    // Converter core answers 30 cycles after each start
    always begin
        @(posedge mclk);
        #2;
        if (conv_start === 1'b1) begin
            conv_count++;
            repeat (30) @(posedge mclk);
            #2 conv_done = 1'b1;
            @(posedge mclk);
            #2 conv_done = 1'b0;
        end
    end
    task automatic address(input logic [7:0] a, output logic ack);
        logic [7:0] rx;
        int h;
        u_bus_master_model.start();
        u_bus_master_model.xfer(a, 1'b1, rx, ack, h);
    endtask
    task automatic read_result(input logic [13:0] d, input logic last);
        logic [7:0] hi, lo;
        logic a;
        int held, h;
        conv_result = '{data: d, trailing_sub_bit_high: 1'b1, trailing_sub_bit_low: 1'b0};
        u_bus_master_model.xfer(8'hff, 1'b0, hi, a, held);
        u_bus_master_model.xfer(8'hff, last, lo, a, h);
        u_bus_master_model.half();
        `CHK(hi, d[13:6], "msb byte")
        `CHK(lo, {d[5:0], 2'h2}, "lsb byte")
        `CHK(held > 20, 1'b1, "no stretch")
    endtask
    task automatic t_normal();
        logic ack;
        int n;
        n = conv_count;
        address(8'h75, ack);
        u_bus_master_model.half();
        `CHK(ack, 1'b1, "no ack")
        `CHK(converter_powered, 1'b1, "not powered")
        `CHK(reference_enabled, 1'b1, "ref off")
        read_result(14'h2a5c, 1'b1);
        `CHK(conv_count, n + 1, "conv count")
        `CHK(converter_powered, 1'b0, "still powered")
        `CHK(reference_enabled, 1'b1, "ref dropped")
        u_bus_master_model.stop();
        $display("normal test done");
    endtask
    task automatic t_continuous();
        logic ack;
        int n;
        n = conv_count;
        address(8'h75, ack);
        read_result(14'h3fff, 1'b0);
        `CHK(converter_powered, 1'b1, "no reconversion")
        read_result(14'h0001, 1'b1);
        `CHK(conv_count, n + 2, "conv count")
        u_bus_master_model.stop();
        $display("continuous test done");
    endtask
    task automatic t_shutdown();
        logic ack;
        address(8'h74, ack);
        read_result(14'h1234, 1'b0);
        `CHK(reference_enabled, 1'b1, "ref early off")
        read_result(14'h0abc, 1'b1);
        `CHK(reference_enabled, 1'b0, "ref on")
        `CHK(reference_buffer_enabled, 1'b0, "buffer on")
        u_bus_master_model.stop();
        $display("shutdown test done");
    endtask
    task automatic t_wrong();
        logic ack;
        int n;
        n = conv_count;
        for (int i = 0; i < 2; i++) begin
            address(i == 0 ? 8'h77 : 8'hf5, ack);
            u_bus_master_model.half();
            `CHK(ack, 1'b0, "acked")
            `CHK(converter_powered, 1'b0, "powered")
            u_bus_master_model.stop();
        end
        `CHK(conv_count, n, "converted")
        $display("address test done");
    endtask
    task automatic t_external();
        logic ack;
        reference_adjust_pin = 1'b1;
        for (int i = 0; i < 2; i++) begin
            address({7'h3a, i[0]}, ack);
            u_bus_master_model.half();
            `CHK(converter_powered, 1'b1, "not powered")
            `CHK(reference_enabled, 1'b0, "ref on")
            read_result(14'h2000, 1'b1);
            `CHK(converter_powered, 1'b0, "still powered")
            `CHK(reference_enabled, 1'b0, "ref on")
            u_bus_master_model.stop();
        end
        reference_adjust_pin = 1'b0;
        $display("external test done");
    endtask
    task automatic t_wake();
        logic ack;
        `CHK(reference_enabled, 1'b0, "ref not asleep")
        address(8'h75, ack);
        u_bus_master_model.half();
        `CHK(reference_enabled, 1'b1, "ref not waking")
        // dummy read; core model settles at once, so no settle wait
        read_result(14'h1555, 1'b1);
        `CHK(reference_enabled, 1'b1, "ref asleep")
        `CHK(reference_buffer_enabled, 1'b1, "buffer off")
        u_bus_master_model.stop();
        $display("wake test done");
    endtask
    task automatic t_reset();
        `CHK(converter_powered, 1'b0, "powered")
        `CHK(reference_enabled, 1'b0, "ref on")
        `CHK(bus_drive, 2'h3, "bus driven")
        $display("reset test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge hung) begin
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge mclk);
        #2 reset_n = 1'b1;
        repeat (6) @(posedge mclk);
        #2;
        t_reset();
        t_normal();
        t_continuous();
        t_shutdown();
        t_wrong();
        t_external();
        t_wake();
        finish_test();
    end
endmodule
`default_nettype wire

// ### tb/bus_master_model.sv
`default_nettype none
module bus_master_model (
    // Clock
    input wire logic mclk,
    // Resolved wire levels
    input wire logic scl,
    input wire logic sda,
    // Own open-drain drive, 1 releases the wire
    output logic scl_drv,
    output logic sda_drv,
    output logic hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        hung = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge mclk);
        #2;
    endtask
    // Clock high phase waits out stretching, bounded
    task automatic rise(output int held);
        held = 0;
        scl_drv = 1'b1;
        half();
        while (scl !== 1'b1) begin
            @(posedge mclk);
            #2;
            held++;
            if (held > 500) hung = 1'b1;
        end
        // A stretched clock still gets a full high phase once released
        if (held > 0) half();
    endtask
    task automatic start();
        half();
        sda_drv = 1'b0;
        half();
        scl_drv = 1'b0;
    endtask
    task automatic clk_bit(input logic b, output logic s, output int held);
        sda_drv = b;
        half();
        rise(held);
        s = sda;
        scl_drv = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack_seen, output int held);
        logic s;
        int h;
        held = 0;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], s, h);
            rx[i] = s;
            held += h;
        end
        clk_bit(ack_in, s, h);
        ack_seen = !s;
    endtask
    task automatic stop();
        half();
        sda_drv = 1'b0;
        half();
        scl_drv = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// ### verilog/adc_power_reference_sequencer.sv
`include "adc_seq_map.svh"
`default_nettype none
module adc_power_reference_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Two-wire bus, open drain
    input wire bus_pins_t bus_in,
    output bus_drive_t bus_drive,
    output logic scl_out,
    output logic sda_out,
    // Straps
    input wire logic [3:0] address_select_pins,
    input wire logic reference_adjust_pin,
    // Converter core
    input wire logic conv_done,
    input wire conv_result_t conv_result,
    output logic conv_start,
    output logic converter_powered,
    output logic reference_enabled,
    output logic reference_buffer_enabled
);
    logic rst_s1_q, rst_n;
    logic [1:0] scl_q, sda_q;
    logic [3:0] sel_s1_q, sel_q;
    logic ext_s1_q, ext_q;
    logic scl_prev_q, sda_prev_q;
    logic scl_rise, scl_fall, start_ev, stop_ev, addr_hit, nack_ev;

    seq_state_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] addr_q, addr_d;
    logic [15:0] shift_q, shift_d;
    logic byte_q, byte_d;
    logic ack_q, ack_d;
    logic sda_low_q, sda_low_d;
    logic scl_low_q, scl_low_d;
    logic start_q, start_d;
    logic pwr_q, pwr_d;
    logic ref_on_q, ref_on_d;
    logic armed_q, armed_d;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Pin synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 2'h3;
            sda_q <= 2'h3;
            sel_s1_q <= 4'h0;
            sel_q <= 4'h0;
            ext_s1_q <= 1'b0;
            ext_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_q <= {scl_q[0], bus_in.scl};
            sda_q <= {sda_q[0], bus_in.sda};
            sel_s1_q <= address_select_pins;
            sel_q <= sel_s1_q;
            ext_s1_q <= reference_adjust_pin;
            ext_q <= ext_s1_q;
            scl_prev_q <= scl_q[1];
            sda_prev_q <= sda_q[1];
        end
    end

    assign scl_rise = scl_q[1] && !scl_prev_q;
    assign scl_fall = !scl_q[1] && scl_prev_q;
    assign start_ev = scl_q[1] && scl_prev_q && sda_prev_q && !sda_q[1];
    assign stop_ev = scl_q[1] && scl_prev_q && !sda_prev_q && sda_q[1];
    assign addr_hit = (st_q == ST_AACK) && scl_fall && !start_ev;
    assign nack_ev = (st_q == ST_MACK) && scl_rise && sda_q[1];

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        shift_d = shift_q;
        byte_d = byte_q;
        ack_d = ack_q;
        sda_low_d = sda_low_q;
        start_d = 1'b0;
        pwr_d = pwr_q;
        ref_on_d = ref_on_q;
        armed_d = armed_q;
        if (start_ev) begin
            st_d = ST_ADDR;
            cnt_d = 3'h0;
            sda_low_d = 1'b0;
        end else if (stop_ev) begin
            st_d = ST_IDLE;
            sda_low_d = 1'b0;
            pwr_d = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    sda_low_d = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        addr_d = {addr_q[6:0], sda_q[1]};
                        cnt_d = cnt_q + 3'h1;
                    end
                    if (scl_rise && cnt_q == `BIT_LAST) begin
                        st_d = ST_AACK;
                    end
                end
                ST_AACK: begin
                    if (addr_q[7:1] != {`ADDR_FIXED, sel_q}) begin
                        st_d = ST_IDLE;
                    end else if (scl_fall && !sda_low_q) begin
                        sda_low_d = 1'b1;
                    end else if (scl_fall) begin
                        st_d = ST_CONV;
                        sda_low_d = 1'b0;
                        start_d = 1'b1;
                        pwr_d = 1'b1;
                        byte_d = 1'b0;
                        if (!ext_q) begin
                            ref_on_d = 1'b1;
                            armed_d = !addr_q[0];
                        end
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        pwr_d = 1'b0;
                        shift_d = conv_result;
                        st_d = ST_TX;
                        cnt_d = 3'h0;
                        byte_d = 1'b0;
                        sda_low_d = !conv_result.data[13];
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        shift_d = {shift_q[14:0], 1'b0};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == `BIT_LAST) begin
                            st_d = ST_MACK;
                            sda_low_d = 1'b0;
                        end else begin
                            sda_low_d = !shift_q[14];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        ack_d = !sda_q[1];
                    end
                    if (nack_ev) begin
                        st_d = ST_IDLE;
                        if (armed_q) begin
                            ref_on_d = 1'b0;
                        end
                        armed_d = 1'b0;
                    end else if (scl_fall && ack_q && !byte_q) begin
                        st_d = ST_TX;
                        byte_d = 1'b1;
                        cnt_d = 3'h0;
                        sda_low_d = !shift_q[15];
                    end else if (scl_fall && ack_q) begin
                        st_d = ST_CONV;
                        start_d = 1'b1;
                        pwr_d = 1'b1;
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
        // external mode keeps internal reference off
        if (ext_q) begin
            ref_on_d = 1'b0;
            armed_d = 1'b0;
        end
        scl_low_d = (st_d == ST_CONV);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            addr_q <= 8'h00;
            shift_q <= 16'h0000;
            byte_q <= 1'b0;
            ack_q <= 1'b0;
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b0;
            start_q <= 1'b0;
            pwr_q <= 1'b0;
            ref_on_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            shift_q <= shift_d;
            byte_q <= byte_d;
            ack_q <= ack_d;
            sda_low_q <= sda_low_d;
            scl_low_q <= scl_low_d;
            start_q <= start_d;
            pwr_q <= pwr_d;
            ref_on_q <= ref_on_d;
            armed_q <= armed_d;
        end
    end

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign bus_drive = '{scl_oe_n: !scl_low_q, sda_oe_n: !sda_low_q};
    assign conv_start = start_q;
    assign converter_powered = pwr_q;
    assign reference_enabled = ref_on_q;
    assign reference_buffer_enabled = ref_on_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_idle_off;
        (st_q == ST_IDLE) && $past(st_q == ST_IDLE) |-> !pwr_q;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("converter on while idle");

    property p_hit_power;
        addr_hit && sda_low_q && addr_q[7:1] == {`ADDR_FIXED, sel_q} |=> pwr_q && start_q;
    endproperty
    a_hit_power: assert property (p_hit_power) else $error("no power-up on address");

    property p_done_off;
        (st_q == ST_CONV) && conv_done && !start_ev && !stop_ev |=> !pwr_q ##0 st_q == ST_TX;
    endproperty
    a_done_off: assert property (p_done_off) else $error("converter kept on");

    property p_stretch;
        (st_q == ST_CONV) |=> (st_q == ST_CONV) |-> !bus_drive.scl_oe_n;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held");

    property p_ext_ignore;
        ext_q |=> !armed_q && !ref_on_q;
    endproperty
    a_ext_ignore: assert property (p_ext_ignore) else $error("read/write honoured in ext");

    property p_nack_off;
        nack_ev && armed_q && !start_ev && !stop_ev |=> !ref_on_q && !armed_q;
    endproperty
    a_nack_off: assert property (p_nack_off) else $error("reference not shut down");

    property p_ref_wake;
        addr_hit && sda_low_q && !ext_q && addr_q[7:1] == {`ADDR_FIXED, sel_q}
            |=> ref_on_q && (armed_q == !$past(addr_q[0]));
    endproperty
    a_ref_wake: assert property (p_ref_wake) else $error("reference not woken");

    property p_load;
        (st_q == ST_CONV) && conv_done && !start_ev && !stop_ev
            |=> shift_q == $past(conv_result) && sda_low_q == !$past(conv_result.data[13]);
    endproperty
    a_load: assert property (p_load) else $error("result not loaded");

    property p_ref_fall;
        $fell(ref_on_q) |-> $past(ext_q) || $past(nack_ev && armed_q);
    endproperty
    a_ref_fall: assert property (p_ref_fall) else $error("reference dropped early");
endmodule
`default_nettype wire
